// ### core/ext_regs_pkg.sv
package ext_regs_pkg;

    // =====================================================================
    // Management addressing
    // =====================================================================
    localparam logic [4:0]  DEV_ADDR          = 5'h1E;
    localparam logic [15:0] OFF_IND_POINTER   = 16'h001E;
    localparam logic [15:0] OFF_IND_DATA      = 16'h001F;
    localparam logic [15:0] OFF_ALIGN_POS     = 16'h8003;
    localparam logic [15:0] OFF_ALIGN_NEG     = 16'h8004;
    localparam logic [15:0] OFF_AUTO_CHECK    = 16'h8021;
    localparam logic [15:0] OFF_SW_ON         = 16'h802A;
    localparam logic [15:0] OFF_SW_OFF        = 16'h802B;
    localparam logic [15:0] OFF_SW_FILL       = 16'h802C;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [15:0] RST_IND_POINTER   = 16'h0000;
    localparam logic [9:0]  RST_ALIGN_POS     = 10'h283;
    localparam logic [9:0]  RST_ALIGN_NEG     = 10'h17C;
    localparam logic [6:0]  RST_AUTO_CHECK    = 7'h0F;
    localparam logic [9:0]  RST_SW_ON         = 10'h2FD;
    localparam logic [9:0]  RST_SW_OFF        = 10'h2FD;
    localparam logic [9:0]  RST_SW_FILL       = 10'h207;

    // =====================================================================
    // Field layout
    // =====================================================================
    localparam int CHAR_W          = 10;
    localparam int CHAN_N          = 2;
    localparam int BIT_PLL_OFF     = 6;
    localparam int BIT_LOS_OFF     = 5;
    localparam int BIT_SYNC_OFF    = 4;
    localparam int BIT_SQUELCH     = 3;
    localparam int AUTO_W          = 7;

    typedef enum logic [1:0] {
        MODE_OTHER   = 2'b00,
        MODE_ONE_GIG = 2'b01,
        MODE_TEN_GIG = 2'b10
    } line_mode_t;

    typedef enum logic [0:0] {
        SW_OFF = 1'b0,
        SW_ON  = 1'b1
    } sw_state_t;

endpackage

// ### core/ext_access_vendor_ctrl_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Registers answer only at device address 0x1E
// - Pointer register at 0x001E, resets to zero
// - Data window reaches register named by pointer; code does so in Clause 22 access only
// - Vendor registers reachable directly and through window; window works in Clause 22 access only
// - Each channel holds its own register copy
// - Two alignment characters, defaults 283 and 17C
// - Upper bits 15:10 of characters read zero
// - Bit 6 set skips PLL lock check
// - Bit 5 set skips signal loss check
// - Bit 4 set skips sync check
// - Bit 3 flattens recovered clock during signal loss when recovered clock selected
// - Low field resets 111, register reads 0x000F
// - Matching ON pattern turns switch on
// - Matching OFF pattern turns switch off in 1G and 10G
// - Fill character defaults to 207 in 10G
module ext_access_vendor_ctrl_regs (
    // Clock and reset
    input  wire logic                               mclk,
    input  wire logic                               nrst,
    // Management access, one strobe per access
    input  wire logic                               mgmt_req,
    input  wire logic                               mgmt_write,
    input  wire logic                               mgmt_clause22,
    input  wire logic [4:0]                         mgmt_dev,
    input  wire logic [0:0]                         mgmt_chan,
    input  wire logic [15:0]                        mgmt_addr,
    input  wire logic [15:0]                        mgmt_wdata,
    output logic                                    mgmt_ack,
    output logic [15:0]                             mgmt_rdata,
    // Datapath mode per channel
    input  wire logic [ext_regs_pkg::CHAN_N*2-1:0]  line_mode,
    // Health indications per channel (asynchronous)
    input  wire logic [ext_regs_pkg::CHAN_N-1:0]    pll_locked,
    input  wire logic [ext_regs_pkg::CHAN_N-1:0]    line_signal_absent,
    input  wire logic [ext_regs_pkg::CHAN_N-1:0]    sync_ok,
    input  wire logic [ext_regs_pkg::CHAN_N-1:0]    recovered_clk_selected,
    input  wire logic [ext_regs_pkg::CHAN_N-1:0]    recovered_clk,
    // Transmit data switch per channel
    input  wire logic [ext_regs_pkg::CHAN_N*10-1:0] tx_char_in,
    output logic [ext_regs_pkg::CHAN_N*10-1:0]      tx_char_out,
    output logic [ext_regs_pkg::CHAN_N-1:0]         tx_switch_on,
    // Check results, clock output and alignment characters per channel
    output logic [ext_regs_pkg::CHAN_N-1:0]         health_fault,
    output logic [ext_regs_pkg::CHAN_N-1:0]         clock_output_pin,
    output logic [ext_regs_pkg::CHAN_N*10-1:0]      align_char_positive,
    output logic [ext_regs_pkg::CHAN_N*10-1:0]      align_char_negative
);
    import ext_regs_pkg::*;

    // =====================================================================
    // Access decode
    // =====================================================================
    logic        hit;
    logic [15:0] eff_addr;
    logic        to_window;
    logic [15:0] ptr_q [CHAN_N];
    logic [15:0] rd_d;

    assign hit       = mgmt_req && (mgmt_dev == DEV_ADDR);
    assign to_window = mgmt_addr == OFF_IND_DATA;
    // Window redirects to the pointed register; pointer itself is never redirected
    assign eff_addr  = to_window ? ptr_q[mgmt_chan] : mgmt_addr;

    // =====================================================================
    // Per channel registers and datapath
    // =====================================================================
    logic [15:0] rd_chan [CHAN_N];

    genvar c;
    generate
        for (c = 0; c < CHAN_N; c++) begin : g_ch
            logic [9:0]          apos_q;
            logic [9:0]          aneg_q;
            logic [AUTO_W-1:0]   auto_q;
            logic [9:0]          on_q;
            logic [9:0]          off_q;
            logic [9:0]          fill_q;
            logic                wr;
            logic [1:0]          pll_s;
            logic [1:0]          los_s;
            logic [1:0]          syn_s;
            logic [1:0]          sel_s;
            logic [1:0]          clk_s;
            logic [9:0]          ch;
            logic                gig;
            sw_state_t           sw_q;
            logic                clk_flat;

            // Window writes only in Clause 22 mode, direct access otherwise
            assign wr = hit && mgmt_write && (mgmt_chan == 1'(c))
                        && (!to_window || mgmt_clause22);

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    ptr_q[c] <= RST_IND_POINTER;
                end else if (wr && mgmt_clause22 && mgmt_addr == OFF_IND_POINTER) begin
                    ptr_q[c] <= mgmt_wdata;
                end
            end

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    apos_q <= RST_ALIGN_POS;
                    aneg_q <= RST_ALIGN_NEG;
                    auto_q <= RST_AUTO_CHECK;
                    on_q   <= RST_SW_ON;
                    off_q  <= RST_SW_OFF;
                    fill_q <= RST_SW_FILL;
                end else if (wr) begin
                    case (eff_addr)
                        OFF_ALIGN_POS:  apos_q <= mgmt_wdata[9:0];
                        OFF_ALIGN_NEG:  aneg_q <= mgmt_wdata[9:0];
                        OFF_AUTO_CHECK: auto_q <= mgmt_wdata[AUTO_W-1:0];
                        OFF_SW_ON:      on_q   <= mgmt_wdata[9:0];
                        OFF_SW_OFF:     off_q  <= mgmt_wdata[9:0];
                        OFF_SW_FILL:    fill_q <= mgmt_wdata[9:0];
                        default: begin
                        end
                    endcase
                end
            end

            always_comb begin
                case (eff_addr)
                    OFF_IND_POINTER: rd_chan[c] = ptr_q[c];
                    OFF_ALIGN_POS:   rd_chan[c] = {6'h00, apos_q};
                    OFF_ALIGN_NEG:   rd_chan[c] = {6'h00, aneg_q};
                    OFF_AUTO_CHECK:  rd_chan[c] = {9'h000, auto_q};
                    OFF_SW_ON:       rd_chan[c] = {6'h00, on_q};
                    OFF_SW_OFF:      rd_chan[c] = {6'h00, off_q};
                    OFF_SW_FILL:     rd_chan[c] = {6'h00, fill_q};
                    default:         rd_chan[c] = 16'h0000;
                endcase
            end

            // Health inputs come from other domains
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pll_s <= 2'h0;
                    los_s <= 2'h0;
                    syn_s <= 2'h0;
                    sel_s <= 2'h0;
                    clk_s <= 2'h0;
                end else begin
                    pll_s <= {pll_s[0], pll_locked[c]};
                    los_s <= {los_s[0], line_signal_absent[c]};
                    syn_s <= {syn_s[0], sync_ok[c]};
                    sel_s <= {sel_s[0], recovered_clk_selected[c]};
                    // Recovered clock is foreign too; only slow toggling survives
                    clk_s <= {clk_s[0], recovered_clk[c]};
                end
            end

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    health_fault[c] <= 1'b0;
                end else begin
                    health_fault[c] <= (!auto_q[BIT_PLL_OFF] && !pll_s[1])
                                    || (!auto_q[BIT_LOS_OFF] && los_s[1])
                                    || (!auto_q[BIT_SYNC_OFF] && !syn_s[1]);
                end
            end

            // Clock passes two sync flops and a register, so it lags three mclk;
            // a true clock pin would gate at the pad instead
            assign clk_flat = auto_q[BIT_SQUELCH] && sel_s[1] && los_s[1];
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    clock_output_pin[c] <= 1'b0;
                end else begin
                    clock_output_pin[c] <= clk_flat ? 1'b0 : clk_s[1];
                end
            end

            assign ch  = tx_char_in[c*10 +: 10];
            assign gig = line_mode[c*2 +: 2] == MODE_ONE_GIG
                      || line_mode[c*2 +: 2] == MODE_TEN_GIG;

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    sw_q <= SW_ON;
                end else if (!gig) begin
                    sw_q <= SW_ON;
                end else begin
                    case (sw_q)
                        SW_ON:   if (ch == off_q) sw_q <= SW_OFF;
                        SW_OFF:  if (ch == on_q) sw_q <= SW_ON;
                        default: sw_q <= SW_ON;
                    endcase
                end
            end

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    tx_char_out[c*10 +: 10] <= 10'h000;
                    tx_switch_on[c]         <= 1'b1;
                end else begin
                    tx_switch_on[c]         <= sw_q == SW_ON;
                    tx_char_out[c*10 +: 10] <= (sw_q == SW_OFF) ? fill_q : ch;
                end
            end

            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    align_char_positive[c*10 +: 10] <= RST_ALIGN_POS;
                    align_char_negative[c*10 +: 10] <= RST_ALIGN_NEG;
                end else begin
                    align_char_positive[c*10 +: 10] <= apos_q;
                    align_char_negative[c*10 +: 10] <= aneg_q;
                end
            end
        end
    endgenerate

    // =====================================================================
    // Read answer
    // =====================================================================
    always_comb begin
        rd_d = rd_chan[mgmt_chan];
        if (to_window && !mgmt_clause22) begin
            rd_d = 16'h0000;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mgmt_ack   <= 1'b0;
            mgmt_rdata <= 16'h0000;
        end else begin
            mgmt_ack <= hit;
            if (hit && !mgmt_write) begin
                mgmt_rdata <= rd_d;
            end
        end
    end

    // =====================================================================
    // Checks
    // =====================================================================
    a_ack_follows_hit: assert property (@(posedge mclk) disable iff (!nrst)
        mgmt_req |=> mgmt_ack == $past(mgmt_dev == DEV_ADDR))
        else $error("ack does not follow a decoded request");

    a_ptr_write_lands: assert property (@(posedge mclk) disable iff (!nrst)
        hit && mgmt_write && mgmt_clause22 && mgmt_addr == OFF_IND_POINTER && mgmt_chan == 1'b0
        |=> ptr_q[0] == $past(mgmt_wdata))
        else $error("pointer write does not land");

    a_window_ignored: assert property (@(posedge mclk) disable iff (!nrst)
        hit && !mgmt_write && to_window && !mgmt_clause22 |=> mgmt_rdata == 16'h0000)
        else $error("window read outside clause 22");

    a_char_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
        hit && !mgmt_write && eff_addr >= OFF_SW_ON && eff_addr <= OFF_SW_FILL
        |=> mgmt_rdata[15:10] == 6'h00)
        else $error("character upper bits not zero");

    a_auto_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
        hit && !mgmt_write && eff_addr == OFF_AUTO_CHECK |=> mgmt_rdata[15:7] == 9'h000)
        else $error("auto check reserved bits not zero");

    a_fill_when_off: assert property (@(posedge mclk) disable iff (!nrst)
        !tx_switch_on[0] |-> tx_char_out[9:0] == $past(g_ch[0].fill_q))
        else $error("switch off without fill character");

    a_off_on_match: assert property (@(posedge mclk) disable iff (!nrst)
        g_ch[0].gig && g_ch[0].sw_q == SW_ON && g_ch[0].ch == g_ch[0].off_q
        |=> ##1 !tx_switch_on[0])
        else $error("off pattern not honoured");

    a_on_on_match: assert property (@(posedge mclk) disable iff (!nrst)
        g_ch[0].sw_q == SW_OFF && g_ch[0].ch == g_ch[0].on_q |=> ##1 tx_switch_on[0])
        else $error("on pattern not honoured");

    a_clock_flat: assert property (@(posedge mclk) disable iff (!nrst)
        g_ch[0].clk_flat |=> !clock_output_pin[0])
        else $error("clock output not flattened");

    a_los_fault: assert property (@(posedge mclk) disable iff (!nrst)
        !g_ch[0].auto_q[BIT_LOS_OFF] && g_ch[0].los_s[1] |=> health_fault[0])
        else $error("signal loss fault missing");

    a_pll_fault: assert property (@(posedge mclk) disable iff (!nrst)
        !g_ch[0].auto_q[BIT_PLL_OFF] && !g_ch[0].pll_s[1] |=> health_fault[0])
        else $error("pll lock fault missing");

    a_sync_fault: assert property (@(posedge mclk) disable iff (!nrst)
        !g_ch[0].auto_q[BIT_SYNC_OFF] && !g_ch[0].syn_s[1] |=> health_fault[0])
        else $error("sync fault missing");

    a_align_upper_zero: assert property (@(posedge mclk) disable iff (!nrst)
        hit && !mgmt_write && (eff_addr == OFF_ALIGN_POS || eff_addr == OFF_ALIGN_NEG)
        |=> mgmt_rdata[15:10] == 6'h00)
        else $error("alignment upper bits not zero");

    a_window_write_dropped: assert property (@(posedge mclk) disable iff (!nrst)
        hit && mgmt_write && to_window && !mgmt_clause22
        |=> $stable(g_ch[0].auto_q) && $stable(g_ch[1].auto_q))
        else $error("window write outside clause 22 landed");

    a_switch_forced_on: assert property (@(posedge mclk) disable iff (!nrst)
        !g_ch[0].gig |=> ##1 tx_switch_on[0])
        else $error("switch not on outside listed modes");

endmodule

// ### test/mgmt_host.sv
`timescale 1ns/1ns
// ==========================================
// Management host model
// ==========================================
module mgmt_host (
    // Clock
    input  wire logic        mclk,
    // Request side
    output logic             mgmt_req,
    output logic             mgmt_write,
    output logic             mgmt_clause22,
    output logic [4:0]       mgmt_dev,
    output logic [0:0]       mgmt_chan,
    output logic [15:0]      mgmt_addr,
    output logic [15:0]      mgmt_wdata,
    // Answer side
    input  wire logic        mgmt_ack,
    input  wire logic [15:0] mgmt_rdata
);
    initial begin
        {mgmt_req, mgmt_write, mgmt_clause22, mgmt_dev, mgmt_chan} = '0;
        {mgmt_addr, mgmt_wdata} = '0;
    end
    // One strobe cycle; address and data go stale (inverted) afterwards so no late sampling hides
    task automatic xfer(input logic w, c, input logic [4:0] dv, input logic [0:0] ch,
                        input logic [15:0] a, d, output logic [15:0] q, output logic ok);
        int n;
        @(negedge mclk);
        {mgmt_req, mgmt_write, mgmt_clause22, mgmt_dev, mgmt_chan} = {1'b1, w, c, dv, ch};
        {mgmt_addr, mgmt_wdata} = {a, d};
        @(negedge mclk);
        mgmt_req = 1'b0;
        {mgmt_addr, mgmt_wdata} = ~{a, d};
        ok = 1'b0;
        q = '0;
        for (n = 0; n < 4 && !ok; n++) begin
            if (mgmt_ack === 1'b1) begin
                ok = 1'b1;
                q = mgmt_rdata;
            end else begin
                @(negedge mclk);
            end
        end
    endtask
endmodule

// ### test/ext_access_vendor_ctrl_regs_bench.sv
`timescale 1ns/1ns
module ext_access_vendor_ctrl_regs_bench;
    import ext_regs_pkg::*;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        req, wr_en, c22, ack;
    logic [4:0]  dev;
    logic [0:0]  chan;
    logic [15:0] addr, wdata, rdata, q;
    logic [3:0]  line_mode = 4'h0;
    logic [1:0]  pll_locked = 2'b11, los = 2'b00, sync_ok = 2'b11;
    logic [1:0]  rsel = 2'b00, rclk = 2'b00, sw_on, fault, clk_pin;
    logic [19:0] tx_in = '0, tx_out, al_p, al_n;
    logic        ok;
    int          num_errors = 0, total_checks = 0, i, k;
    logic [15:0] ra [7] = '{OFF_IND_POINTER, OFF_ALIGN_POS, OFF_ALIGN_NEG, OFF_AUTO_CHECK,
                            OFF_SW_ON, OFF_SW_OFF, OFF_SW_FILL};
    logic [15:0] rv [7] = '{16'h0000, 16'h0283, 16'h017C, 16'h000F, 16'h02FD, 16'h02FD,
                            16'h0207};

    always #2 mclk = ~mclk;

    ext_access_vendor_ctrl_regs dut (.mclk(mclk), .nrst(nrst), .mgmt_req(req),
        .mgmt_write(wr_en), .mgmt_clause22(c22), .mgmt_dev(dev), .mgmt_chan(chan),
        .mgmt_addr(addr), .mgmt_wdata(wdata), .mgmt_ack(ack), .mgmt_rdata(rdata),
        .line_mode(line_mode), .pll_locked(pll_locked), .line_signal_absent(los),
        .sync_ok(sync_ok), .recovered_clk_selected(rsel), .recovered_clk(rclk),
        .tx_char_in(tx_in), .tx_char_out(tx_out), .tx_switch_on(sw_on),
        .health_fault(fault), .clock_output_pin(clk_pin),
        .align_char_positive(al_p), .align_char_negative(al_n));

    mgmt_host host (.mclk(mclk), .mgmt_req(req), .mgmt_write(wr_en), .mgmt_clause22(c22),
        .mgmt_dev(dev), .mgmt_chan(chan), .mgmt_addr(addr), .mgmt_wdata(wdata),
        .mgmt_ack(ack), .mgmt_rdata(rdata));

    // ==========================================
    // Checking helpers
    // ==========================================
    task automatic chk(input string n, input logic [15:0] e, g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic c, input logic [0:0] ch, input logic [15:0] a, d);
        host.xfer(1'b1, c, DEV_ADDR, ch, a, d, q, ok);
        chk("write ack", 16'h0001, 16'(ok));
    endtask

    task automatic rchk(input logic c, input logic [0:0] ch, input logic [15:0] a, e);
        host.xfer(1'b0, c, DEV_ADDR, ch, a, 16'h0000, q, ok);
        chk("read ack", 16'h0001, 16'(ok));
        chk($sformatf("rdata ch%0d @%h", ch, a), e, q);
    endtask

    // Fault source k: 0 pll unlocked, 1 signal absent, 2 sync lost
    task automatic flt(input int k, input logic [1:0] v);
        pll_locked = (k == 0) ? ~v : 2'b11;
        los = (k == 1) ? v : 2'b00;
        sync_ok = (k == 2) ? ~v : 2'b11;
        repeat (5) @(negedge mclk);
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 4);
        num_errors++;
        wrap_up();
    end

    // ==========================================
    // Test sequence
    // ==========================================
    initial begin
        repeat (16) @(negedge mclk);
        nrst = 1'b1;
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 7; i++) begin
                rchk(1'b1, k[0:0], ra[i], rv[i]);
            end
        end
        wr(1'b0, 1'b0, OFF_ALIGN_POS, 16'hFFFF);
        rchk(1'b0, 1'b0, OFF_ALIGN_POS, 16'h03FF);
        rchk(1'b0, 1'b1, OFF_ALIGN_POS, 16'h0283);
        repeat (3) @(negedge mclk);
        chk("align_p", 16'h03FF, 16'(al_p[9:0]));
        chk("align_n", 16'h017C, 16'(al_n[19:10]));
        host.xfer(1'b1, 1'b0, 5'h1D, 1'b0, OFF_ALIGN_NEG, 16'h0000, q, ok);
        chk("foreign ack", 16'h0000, 16'(ok));
        rchk(1'b0, 1'b0, OFF_ALIGN_NEG, 16'h017C);
        rchk(1'b0, 1'b0, 16'h8005, 16'h0000);
        // Window path: point at auto-check, read through, write through
        wr(1'b1, 1'b0, OFF_IND_POINTER, OFF_AUTO_CHECK);
        rchk(1'b1, 1'b0, OFF_IND_POINTER, OFF_AUTO_CHECK);
        rchk(1'b1, 1'b0, OFF_IND_DATA, 16'h000F);
        wr(1'b1, 1'b0, OFF_IND_DATA, 16'h0070);
        rchk(1'b0, 1'b0, OFF_AUTO_CHECK, 16'h0070);
        rchk(1'b0, 1'b0, OFF_IND_DATA, 16'h0000);
        wr(1'b0, 1'b0, OFF_IND_DATA, 16'h000F);
        rchk(1'b0, 1'b0, OFF_AUTO_CHECK, 16'h0070);
        // One check disabled on ch0 only; ch1 keeps all enabled
        for (k = 0; k < 3; k++) begin
            wr(1'b0, 1'b0, OFF_AUTO_CHECK, 16'h0040 >> k);
            flt(k, 2'b11);
            chk("health_fault", 16'h0002, 16'(fault));
            flt(k, 2'b00);
            chk("health_fault", 16'h0000, 16'(fault));
        end
        // ch0 squelch off (0x0010), ch1 squelch on (0x000F)
        rsel = 2'b11;
        rclk = 2'b11;
        flt(1, 2'b11);
        chk("clock_pin", 16'h0001, 16'(clk_pin));
        flt(1, 2'b00);
        chk("clock_pin", 16'h0003, 16'(clk_pin));
        rclk = 2'b00;
        repeat (5) @(negedge mclk);
        chk("clock_pin", 16'h0000, 16'(clk_pin));
        // Transmit switch, ch0 in each listed mode, ch1 in other mode
        wr(1'b0, 1'b0, OFF_SW_OFF, 16'h0155);
        for (k = 1; k < 3; k++) begin
            line_mode = {2'b00, k[1:0]};
            tx_in = {10'h155, 10'h155};
            @(negedge mclk);
            tx_in = {10'h011, 10'h011};
            repeat (2) @(negedge mclk);
            chk("switch off", 16'h0002, 16'(sw_on));
            chk("ch1 out", 16'h0011, 16'(tx_out[19:10]));
            if (k == 2) begin
                chk("fill out", 16'h0207, 16'(tx_out[9:0]));
            end
            tx_in = {10'h2FD, 10'h2FD};
            @(negedge mclk);
            tx_in = {10'h011, 10'h011};
            repeat (2) @(negedge mclk);
            chk("switch on", 16'h0003, 16'(sw_on));
            chk("pass out", 16'h0011, 16'(tx_out[9:0]));
        end
        wrap_up();
    end
endmodule
